// [rscl_pkg.sv]
// Package for the reset strap configuration latch: register map, field
// positions, reset values, strap bit positions and divider constants.
// Assumes a 32-bit APB register bus and a 100 MHz device clock.
package rscl_pkg;

	// APB register byte offsets
	localparam logic [7:0] RSCL_STRAP_OFS = 8'h00;
	localparam logic [7:0] RSCL_MODE_OFS = 8'h04;
	localparam logic [7:0] RSCL_CTRL_OFS = 8'h08;
	localparam int RSCL_ADDR_W = 8;

	// Positions in the synchronised strap vector
	localparam int RSCL_SB_BYTE_ORDER = 0;
	localparam int RSCL_SB_BOOT_LO = 1;
	localparam int RSCL_SB_BOOT_HI = 2;
	localparam int RSCL_SB_CLK_LO = 3;
	localparam int RSCL_SB_CLK_HI = 4;
	localparam int RSCL_SB_HOST_WIDTH = 5;
	localparam int RSCL_SB_ETH_SEL = 6;
	localparam int RSCL_SB_GP0 = 7;
	localparam int RSCL_SB_EXT_CLK = 8;
	localparam int RSCL_SYNC_W = 9;
	localparam int RSCL_STRAP_W = 8;

	// Strap register field positions (capture done flag above the captured levels)
	localparam int RSCL_ST_DONE = 8;

	// Mode register field positions (decoded configuration)
	localparam int RSCL_MD_HOST_EN = 0;
	localparam int RSCL_MD_WIDE = 1;
	localparam int RSCL_MD_NARROW = 2;
	localparam int RSCL_MD_ETHERNET_SELECT_STRAP = 3;
	localparam int RSCL_MD_LOW_HIZ = 4;
	localparam int RSCL_MD_UP_HIZ = 5;
	localparam int RSCL_MD_INVALID = 6;
	localparam int RSCL_MD_BOOT_RSV = 7;
	localparam int RSCL_MD_CLK_RSV = 8;
	localparam int RSCL_MD_LITTLE = 9;
	localparam int RSCL_MD_ALWAYS_ON = 10;

	// Control register fields and reset value
	localparam int RSCL_CT_TICK_EN = 0;
	localparam logic RSCL_CTRL_RST = 1'b0;

	// Byte order encodings
	localparam logic RSCL_BIG_ENDIAN = 1'b0;
	localparam logic RSCL_LITTLE_ENDIAN = 1'b1;

	// Boot source encodings
	localparam logic [1:0] RSCL_BOOT_NONE = 2'h0;
	localparam logic [1:0] RSCL_BOOT_HOST = 2'h1;
	localparam logic [1:0] RSCL_BOOT_RSV = 2'h2;
	localparam logic [1:0] RSCL_BOOT_ROM8 = 2'h3;

	// External memory clock source encodings
	localparam logic [1:0] RSCL_CLK_EXT = 2'h0;
	localparam logic [1:0] RSCL_CLK_DIV4 = 2'h1;
	localparam logic [1:0] RSCL_CLK_DIV6 = 2'h2;
	localparam logic [1:0] RSCL_CLK_RSV = 2'h3;

	// Divider constants for the CPU-derived memory clock ticks
	localparam int RSCL_DIV_W = 3;
	localparam logic [RSCL_DIV_W-1:0] RSCL_DIV4 = 3'h4;
	localparam logic [RSCL_DIV_W-1:0] RSCL_DIV6 = 3'h6;
	localparam logic [RSCL_DIV_W-1:0] RSCL_DIV_NONE = 3'h0;
	localparam logic [RSCL_DIV_W-1:0] RSCL_DIV_ONE = 3'h1;

	// Capture sequencer states, Gray coded along the path
	typedef enum logic [1:0] {
		RSCL_CAP_WAIT = 2'h0,
		RSCL_CAP_LOAD = 2'h1,
		RSCL_CAP_HOLD = 2'h3
	} rscl_cap_state_t;

endpackage

// [rscl_sync.sv]
// Two-stage synchroniser bank for strap pins and the external clock pin.
// Assumes its inputs are asynchronous to clk; the stages hold no reset so
// that they already track the pins while device reset is asserted.
`timescale 1ns/1ps
module rscl_sync
	import rscl_pkg::*;
#(
	parameter int WIDTH = RSCL_SYNC_W
)
(
	input wire logic clk,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;

	// One pair of flip-flops per pin; the first stage feeds only the second
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			always_ff @(posedge clk)
			begin
				meta_reg[i] <= async_in[i];
				sync_out[i] <= meta_reg[i];
			end
		end
	endgenerate

endmodule // rscl_sync

// [rscl_latch.sv]
// Reset strap configuration latch: captures configuration straps at reset,
// decodes byte order, boot source, memory clock source and host port /
// Ethernet pin sharing, and shows the result over an APB slave.
// Assumes straps are held steady by board pulls while arst_n is low and for a few cycles after it rises.
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module rscl_latch
	import rscl_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	// Strap pins and the external memory clock pin
	input wire logic byte_order_strap,
	input wire logic [3:0] extmem_address_pins,
	input wire logic host_width_strap,
	input wire logic ethernet_select_strap,
	input wire logic general_pin_bank0,
	input wire logic extmem_input_clock,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [RSCL_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Decoded configuration
	output logic byte_order_mode,
	output logic [1:0] boot_mode,
	output logic boot_mode_reserved,
	output logic [1:0] extmem_clock_select,
	output logic extmem_clock_reserved,
	output logic extmem_clock_tick,
	output logic host_port_enable,
	output logic host_port_wide_mode,
	output logic host_port_narrow_mode,
	output logic ethernet_mac_enable,
	output logic host_data_lower_oe_allow,
	output logic host_data_upper_oe_allow,
	output logic host_data_lower_hiz,
	output logic host_data_upper_hiz,
	output logic mac_owns_upper_pins,
	output logic config_invalid,
	output logic always_on_periph_enable,
	output logic config_captured
);

	// Reset synchroniser: asynchronous assert, two-flop release
	logic rst_meta_reg;
	logic rst_n_reg;

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rst_meta_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_n_reg <= rst_meta_reg;
		end
	end

	// Strap and external clock synchronisation
	logic [RSCL_SYNC_W-1:0] pins_async;
	logic [RSCL_SYNC_W-1:0] pins_sync;

	assign pins_async = {extmem_input_clock, general_pin_bank0, ethernet_select_strap,
		host_width_strap, extmem_address_pins, byte_order_strap};

	rscl_sync #(
		.WIDTH(RSCL_SYNC_W)
	) u_sync (
		.clk(ref_clk),
		.async_in(pins_async),
		.sync_out(pins_sync)
	);

	// Divider length for a memory clock source code; zero means no divider
	function automatic logic [RSCL_DIV_W-1:0] div_of(input logic [1:0] sel);
		logic [RSCL_DIV_W-1:0] d;
		d = RSCL_DIV_NONE;
		if (sel == RSCL_CLK_DIV4)
			d = RSCL_DIV4;
		else if (sel == RSCL_CLK_DIV6)
			d = RSCL_DIV6;
		return d;
	endfunction

	// Capture sequencer: waits out reset, loads once, then holds
	rscl_cap_state_t cap_state_reg;
	rscl_cap_state_t cap_state_next;

	always_comb
	begin
		cap_state_next = cap_state_reg;
		unique case (cap_state_reg)
			RSCL_CAP_WAIT: cap_state_next = RSCL_CAP_LOAD;
			RSCL_CAP_LOAD: cap_state_next = RSCL_CAP_HOLD;
			RSCL_CAP_HOLD: cap_state_next = RSCL_CAP_HOLD; // Frozen until reset
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			cap_state_reg <= RSCL_CAP_WAIT;
		else
			cap_state_reg <= cap_state_next;
	end

	// Captured strap levels; loaded only in the load state, at reset release
	logic [RSCL_STRAP_W-1:0] strap_reg;

	always_ff @(posedge ref_clk or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			strap_reg <= '0;
		else if (cap_state_reg == RSCL_CAP_LOAD)
			strap_reg <= pins_sync[RSCL_STRAP_W-1:0]; // Levels held in reset
	end

	// Named views of the captured straps
	logic cap_byte_order;
	logic [1:0] cap_boot;
	logic [1:0] cap_clk;
	logic cap_width;
	logic cap_eth;
	logic cap_gp0;
	logic cap_done;

	assign cap_byte_order = strap_reg[RSCL_SB_BYTE_ORDER];
	assign cap_boot = strap_reg[RSCL_SB_BOOT_HI:RSCL_SB_BOOT_LO];
	assign cap_clk = strap_reg[RSCL_SB_CLK_HI:RSCL_SB_CLK_LO];
	assign cap_width = strap_reg[RSCL_SB_HOST_WIDTH];
	assign cap_eth = strap_reg[RSCL_SB_ETH_SEL];
	assign cap_gp0 = strap_reg[RSCL_SB_GP0];
	assign cap_done = (cap_state_reg == RSCL_CAP_HOLD);

	// Byte order, boot source and memory clock source
	always_ff @(posedge ref_clk or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			byte_order_mode <= RSCL_LITTLE_ENDIAN;
			boot_mode <= RSCL_BOOT_NONE;
			boot_mode_reserved <= 1'b0;
			extmem_clock_select <= RSCL_CLK_EXT;
			extmem_clock_reserved <= 1'b0;
		end
		else
		begin
			// 0 big, 1 little; straps not live pins
			byte_order_mode <= cap_done ? cap_byte_order : RSCL_LITTLE_ENDIAN;
			boot_mode <= cap_done ? cap_boot : RSCL_BOOT_NONE;
			boot_mode_reserved <= cap_done && (cap_boot == RSCL_BOOT_RSV);
			extmem_clock_select <= cap_done ? cap_clk : RSCL_CLK_EXT;
			extmem_clock_reserved <= cap_done && (cap_clk == RSCL_CLK_RSV);
		end
	end

	// Host port and Ethernet pin sharing from the captured straps only
	always_ff @(posedge ref_clk or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			host_port_enable <= 1'b0;
			host_port_wide_mode <= 1'b0;
			host_port_narrow_mode <= 1'b0;
			ethernet_mac_enable <= 1'b0;
			host_data_lower_oe_allow <= 1'b0;
			host_data_upper_oe_allow <= 1'b0;
			host_data_lower_hiz <= 1'b1;
			host_data_upper_hiz <= 1'b1;
			mac_owns_upper_pins <= 1'b0;
		end
		else if (!cap_done)
		begin
			// Nothing drives the shared pins until the straps are in
			host_port_enable <= 1'b0;
			host_port_wide_mode <= 1'b0;
			host_port_narrow_mode <= 1'b0;
			ethernet_mac_enable <= 1'b0;
			host_data_lower_oe_allow <= 1'b0;
			host_data_upper_oe_allow <= 1'b0;
			host_data_lower_hiz <= 1'b1;
			host_data_upper_hiz <= 1'b1;
			mac_owns_upper_pins <= 1'b0;
		end
		else
		begin
			// Host port off only when both straps are high
			host_port_enable <= !(cap_eth && cap_width);
			// Wide host bus needs width high and Ethernet low
			host_port_wide_mode <= cap_width && !cap_eth;
			// Narrow host bus whenever width is low
			host_port_narrow_mode <= !cap_width;
			// MAC and management on only with the Ethernet strap
			ethernet_mac_enable <= cap_eth;
			// Lower pins belong to the host unless the host is off
			host_data_lower_oe_allow <= !(cap_eth && cap_width);
			host_data_lower_hiz <= cap_eth && cap_width;
			// Upper pins: host in wide mode, MAC with Ethernet, else idle
			host_data_upper_oe_allow <= cap_width && !cap_eth;
			host_data_upper_hiz <= !cap_width && !cap_eth;
			mac_owns_upper_pins <= cap_eth;
		end
	end

	// Invalid configuration flag and always-available peripherals
	always_ff @(posedge ref_clk or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			config_invalid <= 1'b0;
			always_on_periph_enable <= 1'b0;
			config_captured <= 1'b0;
		end
		else
		begin
			config_invalid <= cap_done && cap_gp0; // Pin zero high in reset
			always_on_periph_enable <= cap_done; // Independent of straps
			config_captured <= cap_done;
		end
	end

	// Memory clock ticks: divided CPU clock or edges of the external clock
	logic [RSCL_DIV_W-1:0] div_len;
	logic [RSCL_DIV_W-1:0] div_cnt_reg;
	logic ext_clk_prev_reg;
	logic ctrl_tick_en_reg;

	assign div_len = div_of(extmem_clock_select);

	always_ff @(posedge ref_clk or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			div_cnt_reg <= RSCL_DIV_NONE;
			ext_clk_prev_reg <= 1'b0;
			extmem_clock_tick <= 1'b0;
		end
		else
		begin
			ext_clk_prev_reg <= pins_sync[RSCL_SB_EXT_CLK];
			if (!ctrl_tick_en_reg || !config_captured || extmem_clock_reserved)
			begin
				div_cnt_reg <= RSCL_DIV_NONE;
				extmem_clock_tick <= 1'b0;
			end
			else if (div_len == RSCL_DIV_NONE)
			begin
				// External source: one tick per rising edge of the input clock
				div_cnt_reg <= RSCL_DIV_NONE;
				extmem_clock_tick <= pins_sync[RSCL_SB_EXT_CLK] && !ext_clk_prev_reg;
			end
			else if (div_cnt_reg >= div_len - RSCL_DIV_ONE)
			begin
				// One tick every four or six device clocks
				div_cnt_reg <= RSCL_DIV_NONE;
				extmem_clock_tick <= 1'b1;
			end
			else
			begin
				div_cnt_reg <= div_cnt_reg + RSCL_DIV_ONE;
				extmem_clock_tick <= 1'b0;
			end
		end
	end

	// Register views for readback
	logic [31:0] strap_view;
	logic [31:0] mode_view;

	always_comb
	begin
		strap_view = '0;
		strap_view[RSCL_STRAP_W-1:0] = strap_reg;
		strap_view[RSCL_ST_DONE] = config_captured;
		mode_view = '0;
		mode_view[RSCL_MD_HOST_EN] = host_port_enable;
		mode_view[RSCL_MD_WIDE] = host_port_wide_mode;
		mode_view[RSCL_MD_NARROW] = host_port_narrow_mode;
		mode_view[RSCL_MD_ETHERNET_SELECT_STRAP] = ethernet_mac_enable;
		mode_view[RSCL_MD_LOW_HIZ] = host_data_lower_hiz;
		mode_view[RSCL_MD_UP_HIZ] = host_data_upper_hiz;
		mode_view[RSCL_MD_INVALID] = config_invalid;
		mode_view[RSCL_MD_BOOT_RSV] = boot_mode_reserved;
		mode_view[RSCL_MD_CLK_RSV] = extmem_clock_reserved;
		mode_view[RSCL_MD_LITTLE] = byte_order_mode;
		mode_view[RSCL_MD_ALWAYS_ON] = always_on_periph_enable;
	end

	// APB address decode
	logic apb_setup;
	logic apb_access;
	logic hit_strap;
	logic hit_mode;
	logic hit_ctrl;

	assign apb_setup = psel && !penable;
	assign apb_access = psel && penable && pready;
	assign hit_strap = (paddr == RSCL_STRAP_OFS);
	assign hit_mode = (paddr == RSCL_MODE_OFS);
	assign hit_ctrl = (paddr == RSCL_CTRL_OFS);

	// APB answer: ready, data and error registered in the setup cycle
	always_ff @(posedge ref_clk or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end
		else if (apb_setup)
		begin
			pready <= 1'b1;
			pslverr <= !(hit_strap || hit_mode || hit_ctrl);
			if (pwrite)
				prdata <= '0;
			else if (hit_strap)
				prdata <= strap_view;
			else if (hit_mode)
				prdata <= mode_view;
			else if (hit_ctrl)
				prdata <= {31'h0, ctrl_tick_en_reg};
			else
				prdata <= '0;
		end
		else
		begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end
	end

	// Control register write; strap and mode registers are read-only
	always_ff @(posedge ref_clk or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			ctrl_tick_en_reg <= RSCL_CTRL_RST;
		else if (apb_access && pwrite && hit_ctrl)
			ctrl_tick_en_reg <= pwdata[RSCL_CT_TICK_EN];
	end

endmodule // rscl_latch

// [rscl_latch_monitor.sv]
// Checker for the strap latch: decode relations and hold after capture.
// Assumes it is bound to rscl_latch and sees its ports by name.
`timescale 1ns/1ps
module rscl_latch_monitor
	import rscl_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic byte_order_mode,
	input wire logic [1:0] boot_mode,
	input wire logic boot_mode_reserved,
	input wire logic [1:0] extmem_clock_select,
	input wire logic extmem_clock_reserved,
	input wire logic extmem_clock_tick,
	input wire logic host_port_enable,
	input wire logic host_port_wide_mode,
	input wire logic host_port_narrow_mode,
	input wire logic ethernet_mac_enable,
	input wire logic host_data_upper_oe_allow,
	input wire logic host_data_lower_hiz,
	input wire logic host_data_upper_hiz,
	input wire logic mac_owns_upper_pins,
	input wire logic always_on_periph_enable,
	input wire logic config_captured
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	// Decode relations between the configuration outputs, state before and hold after capture, and tick periods
	a_pre_capture_off: assert property (
		!config_captured |-> !host_port_enable && !ethernet_mac_enable)
		else $error("enable before capture");
	a_boot_rsv_flag: assert property (
		config_captured |-> boot_mode_reserved == (boot_mode == RSCL_BOOT_RSV))
		else $error("boot reserved flag");
	a_clk_rsv_flag: assert property (
		config_captured |->
			extmem_clock_reserved == (extmem_clock_select == RSCL_CLK_RSV))
		else $error("clock reserved flag");
	a_narrow_upper_hiz: assert property (
		config_captured |->
			host_data_upper_hiz == (host_port_narrow_mode && !ethernet_mac_enable))
		else $error("upper hiz wrong");
	a_wide_all_pins: assert property (
		config_captured |->
			host_port_wide_mode == (!host_port_narrow_mode && !ethernet_mac_enable) &&
			host_data_upper_oe_allow == host_port_wide_mode)
		else $error("wide mode wrong");
	a_mac_upper_pins: assert property (
		config_captured |-> mac_owns_upper_pins == ethernet_mac_enable &&
			!(mac_owns_upper_pins && host_data_upper_oe_allow))
		else $error("upper pin owner wrong");
	a_host_off_hiz: assert property (
		config_captured |->
			host_port_enable == !(ethernet_mac_enable && !host_port_narrow_mode) &&
			host_data_lower_hiz == !host_port_enable)
		else $error("host off wrong");
	a_always_on_set: assert property (
		config_captured |-> always_on_periph_enable)
		else $error("always on low");
	a_captured_hold: assert property (
		config_captured |=> config_captured && $stable({byte_order_mode, boot_mode,
			extmem_clock_select, host_port_enable, ethernet_mac_enable}))
		else $error("captured value moved");
	a_div4_period: assert property (
		extmem_clock_tick && extmem_clock_select == RSCL_CLK_DIV4 |=>
			!extmem_clock_tick [*3] ##1 extmem_clock_tick)
		else $error("div4 tick period");
	a_div6_period: assert property (
		extmem_clock_tick && extmem_clock_select == RSCL_CLK_DIV6 |=>
			!extmem_clock_tick [*5] ##1 extmem_clock_tick)
		else $error("div6 tick period");
endmodule // rscl_latch_monitor

bind rscl_latch rscl_latch_monitor i_rscl_latch_monitor (.*);

// [rscl_board_pulls.sv]
// Board pull resistors on the strap pins, reused as outputs after reset.
// Assumes the bench raises hold through reset and a few cycles beyond.
`timescale 1ns/1ps
module rscl_board_pulls
(
	input wire logic [7:0] strap_cfg,
	input wire logic hold,
	output logic byte_order_strap,
	output logic [3:0] extmem_address_pins,
	output logic host_width_strap,
	output logic ethernet_select_strap,
	output logic general_pin_bank0
);
	logic [7:0] lvl;

	// Pulls fix levels in reset; afterwards pins toggle away as alternates
	assign lvl = hold ? strap_cfg : ~strap_cfg;
	assign byte_order_strap = lvl[0];
	assign extmem_address_pins = lvl[4:1];
	assign host_width_strap = lvl[5];
	assign ethernet_select_strap = lvl[6];
	assign general_pin_bank0 = lvl[7]; // Low in reset unless the bench sets strap_cfg[7]
endmodule // rscl_board_pulls

// [rscl_latch_tb.sv]
// Testbench for the strap latch: strap sets across resets, APB reads.
// Assumes the board model supplies straps and the checker is bound.
`timescale 1ns/1ps
module rscl_latch_tb
	import rscl_pkg::*;
;
	logic ref_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic extmem_input_clock = 0, hold = 1;
	logic [7:0] paddr = 0, cfg = 8'h01;
	logic [31:0] pwdata = 0, prdata;
	logic pready, pslverr, byte_order_mode, boot_mode_reserved, extmem_clock_reserved;
	logic extmem_clock_tick, host_port_enable, host_port_wide_mode, host_port_narrow_mode;
	logic ethernet_mac_enable, host_data_lower_oe_allow, host_data_upper_oe_allow;
	logic host_data_lower_hiz, host_data_upper_hiz, mac_owns_upper_pins, config_invalid;
	logic always_on_periph_enable, config_captured;
	logic [1:0] boot_mode, extmem_clock_select;
	wire byte_order_strap, host_width_strap, ethernet_select_strap, general_pin_bank0;
	wire [3:0] extmem_address_pins;
	logic [32:0] rd;
	int err_count = 0, samples_checked = 0, cyc = 0;

	rscl_latch i_rscl_latch (.*);
	rscl_board_pulls i_rscl_board_pulls (.strap_cfg(cfg), .hold(hold), .*);

	always #5 ref_clk = ~ref_clk;

	// Cycle limit and a slow memory input clock
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc % 4 == 0)
			extmem_input_clock <= ~extmem_input_clock;
		if (cyc > 2000)
		begin
			err_count++;
			final_report();
		end
	end

	task final_report();
		if (err_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task chk(input logic [32:0] got, input logic [32:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One APB transfer; rd holds pslverr and prdata from the ready edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		// Only the bench cycle limit bounds this wait
		do
			@(posedge ref_clk);
		while (pready !== 1'b1);
		rd = {pslverr, prdata};
		psel <= 0;
		penable <= 0;
	endtask

	// Reset with one strap set, then check decode, registers and ticks
	task run(input logic [7:0] c);
		logic [10:0] m;
		logic e, w, h;
		logic [32:0] n;
		e = c[6];
		w = c[5];
		h = !(e && w);
		m = {1'b1, c[0], c[4:3] == 2'h3, c[2:1] == 2'h2, c[7], !e && !w, e && w, e, !w,
			w && !e, !(e && w)};
		cfg <= c;
		hold <= 1;
		arst_n <= 0;
		repeat (6) @(posedge ref_clk);
		chk({host_port_enable, ethernet_mac_enable, host_data_lower_hiz,
			host_data_upper_hiz}, 4'h3);
		arst_n <= 1;
		repeat (8) @(posedge ref_clk);
		hold <= 0;
		repeat (4) @(posedge ref_clk);
		chk(byte_order_mode, c[0]);
		chk({boot_mode, boot_mode_reserved}, {c[2:1], c[2:1] == 2'h2});
		chk({extmem_clock_select, extmem_clock_reserved},
			{c[4:3], c[4:3] == 2'h3});
		chk({host_port_narrow_mode, host_data_upper_hiz}, {!w, !e && !w});
		chk({host_port_wide_mode, host_data_upper_oe_allow}, {2{w && !e}});
		chk({ethernet_mac_enable, mac_owns_upper_pins}, {e, e});
		chk({host_port_enable, host_data_lower_oe_allow, host_data_lower_hiz},
			{h, h, !h});
		chk({config_invalid, always_on_periph_enable, config_captured},
			{c[7], 2'h3});
		apb(1, RSCL_STRAP_OFS, 32'hffffffff);
		chk(rd, 33'h0);
		apb(0, RSCL_STRAP_OFS, 0);
		chk(rd, {24'h1, c});
		apb(0, RSCL_MODE_OFS, 0);
		chk(rd, {22'h0, m});
		apb(1, 8'h0c, 32'h5);
		chk(rd, 33'h100000000);
		apb(0, RSCL_CTRL_OFS, 0);
		chk(rd, 33'h0);
		apb(1, RSCL_CTRL_OFS, 32'h1);
		apb(0, RSCL_CTRL_OFS, 0);
		chk(rd, 33'h1);
		n = 0;
		repeat (24)
		begin
			@(posedge ref_clk);
			n += extmem_clock_tick;
		end
		// External clock has an 8-cycle period, so 24 cycles hold three rising edges
		chk(n, c[4] ? (c[3] ? 0 : 4) : (c[3] ? 6 : 3));
	endtask

	// Strap sets cover every boot code, clock code and width/Ethernet pair
	initial
	begin
		run(8'h01);
		run(8'h2a);
		run(8'h55);
		run(8'hfe);
		final_report();
	end
endmodule // rscl_latch_tb
